/* hw/adc_seq_pkg.sv */
// Purpose: shared types of the converter sequencer
// Assumes: nothing
// Notes:   constants live in adc_seq_regs.svh
package adc_seq_pkg;
   typedef logic [1:0] result_format_t;
   typedef logic [4:0] channel_select_t;
   typedef logic [2:0] conv_divider_t;
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_CONVERT,
      SEQ_FINISH
   } seq_state_e;
endpackage

/* hw/adc_seq_regs.svh */
// Purpose: named constants for the converter sequencer
// Assumes: included by its bare name
// Notes:   timing counts are in converter clock ticks, the prescaler in system cycles
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// ============================================================
// result format codes
`define FMT_LEFT         2'h0
`define FMT_RIGHT        2'h1
`define FMT_SIGNED       2'h2
`define FMT_TRUNC        2'h3

// ============================================================
// channel select codes
`define CHAN_LAST_PIN    5'h07
`define CHAN_REF_HIGH    5'h1D
`define CHAN_REF_LOW     5'h1E
`define CHAN_POWER_OFF   5'h1F

// ============================================================
// conversion timing in converter ticks, and SAR trial values
`define TICK_SAMPLE      4'h0
`define TICK_FIRST_TRIAL 4'h1
`define TICK_LAST_TRIAL  4'hA
`define TICK_LAST        4'hF
`define SAR_MSB          4'h9
`define SAR_FIRST_TRIAL  10'h200
`define RESULT_ZERO      10'h000

// ============================================================
// converter clock divider
`define DIV_CODE_MAX     3'h4
`define PRESCALE_DEFAULT 25

// ============================================================
// reset values
`define RST_CHAN         5'h1F
`define RST_BYTE         8'h00
`define RST_DIV          3'h0

`endif

/* hw/adc_sequencer.sv */
// Purpose: control of an eight-channel 10-bit successive approximation converter
// Assumes: comparator and pin inputs are asynchronous; write/read strobes are
//          one-cycle pulses on i_clk_sys
// Notes:   register bits are plain ports; result bytes are held in flip-flops
`include "adc_seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_sequencer #(
   parameter int PRESCALE = `PRESCALE_DEFAULT
) (
   // clock and reset
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_rst_n,
   // status and control register write
   input  wire logic                     i_scr_write,
   input  wire logic                     i_conv_irq_enable,
   input  wire logic                     i_continuous_conv_bit,
   input  wire adc_seq_pkg::channel_select_t i_channel_select_field,
   // clock register write; alternate converter tick
   input  wire logic                     i_clk_cfg_write,
   input  wire adc_seq_pkg::conv_divider_t   i_conv_clock_divider,
   input  wire logic                     i_conv_clock_source_sel,
   input  wire adc_seq_pkg::result_format_t  i_result_format,
   input  wire logic                     i_alt_conv_tick,
   // data register reads
   input  wire logic                     i_read_high,
   input  wire logic                     i_read_low,
   // register readback
   output logic                          o_conv_irq_enable,
   output logic                          o_continuous_conv_bit,
   output adc_seq_pkg::channel_select_t  o_channel_select_field,
   output adc_seq_pkg::conv_divider_t    o_conv_clock_divider,
   output logic                          o_conv_clock_source_sel,
   output adc_seq_pkg::result_format_t   o_result_format,
   output logic                          o_conv_complete_flag,
   output logic [7:0]                    o_result_high_byte,
   output logic [7:0]                    o_result_low_byte,
   output logic                          o_conv_irq,
   output logic                          o_busy,
   // analog core
   input  wire logic                     i_comparator,
   output adc_seq_pkg::channel_select_t  o_mux_select,
   output logic                          o_power_down,
   output logic                          o_sample,
   output logic [9:0]                    o_sar_trial,
   // shared port pins
   input  wire logic [7:0]               i_port_data,
   input  wire logic [7:0]               i_port_ddr,
   input  wire logic [7:0]               i_pin_in,
   output logic [7:0]                    o_pin_out,
   output logic [7:0]                    o_pin_oe,
   output logic [7:0]                    o_port_read
);
   import adc_seq_pkg::*;

   // ============================================================
   // converter clock enable
   conv_tick_if tick_bus ();

   assign tick_bus.divider    = o_conv_clock_divider;
   assign tick_bus.source_sel = o_conv_clock_source_sel;
   assign tick_bus.alt_tick   = i_alt_conv_tick;
   assign tick_bus.restart    = i_scr_write;

   conv_clock_div #(
      .PRESCALE (PRESCALE)
   ) u_div (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .tick_port (tick_bus.src)
   );

   // ============================================================
   // control registers
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_conv_irq_enable      <= 1'b0;
         o_continuous_conv_bit  <= 1'b0;
         o_channel_select_field <= `RST_CHAN;
      end else if (i_scr_write) begin
         o_conv_irq_enable      <= i_conv_irq_enable;
         o_continuous_conv_bit  <= i_continuous_conv_bit;
         o_channel_select_field <= i_channel_select_field;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_conv_clock_divider    <= `RST_DIV;
         o_conv_clock_source_sel <= 1'b0;
         o_result_format         <= `FMT_LEFT;
      end else if (i_clk_cfg_write) begin
         o_conv_clock_divider    <= i_conv_clock_divider;
         o_conv_clock_source_sel <= i_conv_clock_source_sel;
         o_result_format         <= i_result_format;
      end
   end

   // ============================================================
   // input synchronisers
   logic       cmp_meta;
   logic       cmp_sync;
   logic [7:0] pin_meta;
   logic [7:0] pin_sync;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmp_meta <= 1'b0;
         cmp_sync <= 1'b0;
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
      end else begin
         cmp_meta <= i_comparator;
         cmp_sync <= cmp_meta;
         pin_meta <= i_pin_in;
         pin_sync <= pin_meta;
      end
   end

   // ============================================================
   // conversion sequencer
   seq_state_e state;
   logic [3:0] tick_cnt;
   logic [3:0] bit_pos;
   logic       settle_pending;
   logic       powered_off;
   logic       conv_done;

   assign powered_off = (o_channel_select_field == `CHAN_POWER_OFF);
   assign conv_done   = (state == SEQ_FINISH);

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state    <= SEQ_IDLE;
         tick_cnt <= 4'h0;
      end else if (i_scr_write) begin
         state    <= SEQ_CONVERT;
         tick_cnt <= 4'h0;
      end else begin
         unique case (state)
            SEQ_IDLE: begin
               tick_cnt <= 4'h0;
            end
            SEQ_CONVERT: begin
               if (powered_off) begin
                  state <= SEQ_IDLE;
               end else if (tick_bus.tick) begin
                  tick_cnt <= tick_cnt + 4'h1;
                  if (tick_cnt == `TICK_LAST) begin
                     state <= SEQ_FINISH;
                  end
               end
            end
            SEQ_FINISH: begin
               tick_cnt <= 4'h0;
               if (o_continuous_conv_bit || settle_pending) begin
                  state <= SEQ_CONVERT;
               end else begin
                  state <= SEQ_IDLE;
               end
            end
         endcase
      end
   end

   // first conversion after power-up is a throwaway settling pass
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         settle_pending <= 1'b1;
      end else if (powered_off) begin
         settle_pending <= 1'b1;
      end else if (conv_done) begin
         settle_pending <= 1'b0;
      end
   end

   // successive approximation; comparator high keeps the trial bit
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sar_trial <= `RESULT_ZERO;
         bit_pos     <= `SAR_MSB;
         o_sample    <= 1'b0;
      end else if (state == SEQ_CONVERT && tick_bus.tick) begin
         o_sample <= (tick_cnt == `TICK_SAMPLE);
         if (tick_cnt == `TICK_SAMPLE) begin
            o_sar_trial <= `SAR_FIRST_TRIAL;
            bit_pos     <= `SAR_MSB;
         end else if (tick_cnt >= `TICK_FIRST_TRIAL && tick_cnt <= `TICK_LAST_TRIAL) begin
            if (!cmp_sync) begin
               o_sar_trial[bit_pos] <= 1'b0;
            end
            if (bit_pos != 4'h0) begin
               o_sar_trial[bit_pos - 4'h1] <= 1'b1;
               bit_pos                     <= bit_pos - 4'h1;
            end
         end
      end else if (state != SEQ_CONVERT) begin
         o_sample <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_busy       <= 1'b0;
         o_mux_select <= `RST_CHAN;
         o_power_down <= 1'b1;
      end else begin
         o_busy       <= (state != SEQ_IDLE) || i_scr_write;
         o_mux_select <= o_channel_select_field;
         o_power_down <= powered_off;
      end
   end

   // ============================================================
   // result formatting and interlock
   logic       locked;
   logic       result_valid;
   logic       store_result;
   logic       data_read;
   logic [7:0] next_high;
   logic [7:0] next_low;

   assign result_valid = conv_done && !settle_pending;
   assign store_result = result_valid && !locked;
   assign data_read    = i_read_high || i_read_low;

   always_comb begin
      next_high = `RST_BYTE;
      next_low  = `RST_BYTE;
      unique case (o_result_format)
         `FMT_LEFT: begin
            next_high = o_sar_trial[9:2];
            next_low  = {o_sar_trial[1:0], 6'h00};
         end
         `FMT_RIGHT: begin
            next_high = {6'h00, o_sar_trial[9:8]};
            next_low  = o_sar_trial[7:0];
         end
         `FMT_SIGNED: begin
            next_high = {~o_sar_trial[9], o_sar_trial[8:2]};
            next_low  = {o_sar_trial[1:0], 6'h00};
         end
         `FMT_TRUNC: begin
            next_high = `RST_BYTE;
            next_low  = o_sar_trial[9:2];
         end
      endcase
   end

   // every valid result overwrites the data bytes unless interlocked
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_result_high_byte <= `RST_BYTE;
         o_result_low_byte  <= `RST_BYTE;
      end else if (store_result) begin
         o_result_high_byte <= next_high;
         o_result_low_byte  <= next_low;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         locked <= 1'b0;
      end else if (i_read_low || o_result_format == `FMT_TRUNC) begin
         locked <= 1'b0;
      end else if (i_read_high) begin
         locked <= 1'b1;
      end
   end

   // ============================================================
   // completion flag and interrupt; a new result wins over a read or control-write clear, but irq enable keeps the flag clear
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_conv_complete_flag <= 1'b0;
      end else if (o_conv_irq_enable) begin
         o_conv_complete_flag <= 1'b0;
      end else if (store_result) begin
         o_conv_complete_flag <= 1'b1;
      end else if (data_read) begin
         o_conv_complete_flag <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_conv_irq <= 1'b0;
      end else if (!o_conv_irq_enable) begin
         o_conv_irq <= 1'b0;
      end else if (store_result) begin
         o_conv_irq <= 1'b1;
      end else if (data_read || i_scr_write) begin
         o_conv_irq <= 1'b0;
      end
   end

   // ============================================================
   // shared port pin override
   for (genvar pin = 0; pin < 8; pin++) begin : g_pin
      logic taken;
      assign taken = !powered_off && (o_channel_select_field == 5'(pin));
      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
         if (!i_rst_n) begin
            o_pin_out[pin]   <= 1'b0;
            o_pin_oe[pin]    <= 1'b0;
            o_port_read[pin] <= 1'b0;
         end else begin
            o_pin_out[pin]   <= i_port_data[pin];
            o_pin_oe[pin]    <= i_port_ddr[pin] && !taken;
            if (taken) begin
               o_port_read[pin] <= 1'b0;
            end else begin
               o_port_read[pin] <= i_port_ddr[pin] ? i_port_data[pin] : pin_sync[pin];
            end
         end
      end
   end
endmodule
`default_nettype wire

/* hw/conv_clock_div.sv */
// Purpose: makes the converter clock enable from the system clock
// Assumes: alternate tick is a one-cycle enable on i_clk_sys
// Notes:   with the system clock source selected, tick period is PRESCALE times 2**divider system cycles, divider codes above 4 taken as 4
`include "adc_seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module conv_clock_div #(
   parameter int PRESCALE = `PRESCALE_DEFAULT
) (
   // clock and reset
   input  wire logic   i_clk_sys,
   input  wire logic   i_rst_n,
   // divider side
   conv_tick_if.src    tick_port
);
   import adc_seq_pkg::*;

   // ============================================================
   // prescaler and power-of-two stage
   logic [7:0]  pre_cnt;
   logic [3:0]  pow_cnt;
   logic        pre_tick;
   logic [3:0]  pow_mask;
   conv_divider_t div_code;

   always_comb begin
      div_code = (tick_port.divider > `DIV_CODE_MAX) ? `DIV_CODE_MAX : tick_port.divider;
      pow_mask = 4'((5'h01 << div_code) - 5'h01);
      pre_tick = (pre_cnt == 8'(PRESCALE - 1));
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pre_cnt <= 8'h00;
      end else if (tick_port.restart || pre_tick) begin
         pre_cnt <= 8'h00;
      end else begin
         pre_cnt <= pre_cnt + 8'h01;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pow_cnt <= 4'h0;
      end else if (tick_port.restart) begin
         pow_cnt <= 4'h0;
      end else if (pre_tick) begin
         pow_cnt <= (pow_cnt >= pow_mask) ? 4'h0 : pow_cnt + 4'h1;
      end
   end

   // source select: divided system clock or alternate enable
   always_comb begin
      if (tick_port.source_sel) begin
         tick_port.tick = tick_port.alt_tick;
      end else begin
         tick_port.tick = pre_tick && (pow_cnt >= pow_mask);
      end
   end
endmodule
`default_nettype wire

/* hw/conv_tick_if.sv */
// Purpose: carries divider settings and the converter tick
// Assumes: single clock domain
// Notes:   tick is a one-cycle enable
`timescale 1ns/1ps
`default_nettype none
interface conv_tick_if;
   import adc_seq_pkg::*;
   conv_divider_t divider;
   logic          source_sel;
   logic          alt_tick;
   logic          restart;
   logic          tick;
   modport src  (input divider, input source_sel, input alt_tick, input restart, output tick);
   modport sink (output divider, output source_sel, output alt_tick, output restart, input tick);
endinterface
`default_nettype wire

/* tb/adc_core_model.sv */
// Purpose: behavioural analog mux and comparator facing the sequencer
// Assumes: trial code settles before the sequencer samples it
// Notes:   powered down, the comparator output toggles every cycle
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
   // clock
   input  wire logic       i_clk_sys,
   // converter controls
   input  wire logic [9:0] i_sar_trial,
   input  wire logic [4:0] i_mux_select,
   input  wire logic       i_power_down,
   input  wire logic [9:0] i_pin_level [8],
   // comparator
   output logic            o_comparator
);
   logic [9:0] level;
   logic       junk = 1'b0;
   always @(posedge i_clk_sys) begin
      junk <= ~junk;
   end
   always_comb begin
      case (i_mux_select)
         5'h1D:   level = 10'h3FF;
         5'h1E:   level = 10'h000;
         default: level = i_pin_level[i_mux_select[2:0]];
      endcase
   end
   assign o_comparator = i_power_down ? junk : (level >= i_sar_trial);
endmodule
`default_nettype wire

/* tb/adc_sequencer_asserts.sv */
// Purpose: concurrent checks on the sequencer ports
// Assumes: one clock domain, reset active low
// Notes:   bound from the testbench top
`include "adc_seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_asserts #(
   parameter int PRESCALE = 4
) (
   // clock and reset
   input wire logic                          i_clk_sys,
   input wire logic                          i_rst_n,
   // inputs watched
   input wire logic                          i_scr_write,
   input wire adc_seq_pkg::channel_select_t  i_channel_select_field,
   input wire logic                          i_read_high,
   input wire logic                          i_read_low,
   input wire logic [7:0]                    i_port_ddr,
   // outputs watched
   input wire logic                          o_conv_irq_enable,
   input wire logic                          o_conv_complete_flag,
   input wire logic [7:0]                    o_result_high_byte,
   input wire logic [7:0]                    o_result_low_byte,
   input wire adc_seq_pkg::result_format_t   o_result_format,
   input wire logic                          o_conv_irq,
   input wire logic                          o_busy,
   input wire adc_seq_pkg::channel_select_t  o_mux_select,
   input wire logic                          o_power_down,
   input wire logic [7:0]                    o_pin_oe,
   input wire logic [7:0]                    o_port_read
);
   import adc_seq_pkg::*;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   function automatic logic [7:0] sel_mask(channel_select_t c);
      sel_mask = (c[4:3] == 2'h0) ? (8'h01 << c[2:0]) : 8'h00;
   endfunction
   // ============================================================
   // sequences
   sequence pins_settled;
      ($stable(o_mux_select) && $stable(i_port_ddr)) [*2];
   endsequence
   sequence store_seen;
      $changed(o_result_low_byte) || $changed(o_result_high_byte);
   endsequence
   // ============================================================
   // properties
   chk_write_busy: assert property (i_scr_write && i_channel_select_field != `CHAN_POWER_OFF
      |=> o_busy) else $error("busy not raised after control write");
   chk_power_off: assert property (i_scr_write && i_channel_select_field == `CHAN_POWER_OFF
      |=> ##1 o_power_down ##1 !o_busy) else $error("power off did not idle");
   chk_flag_hold: assert property (o_conv_complete_flag && !o_conv_irq_enable
      && !i_read_high && !i_read_low && !i_scr_write |=> o_conv_complete_flag)
      else $error("flag dropped without read");
   chk_flag_clear: assert property (i_read_low && !o_busy
      |=> !o_conv_complete_flag) else $error("flag kept after read");
   chk_flag_irq: assert property (o_conv_irq_enable && $past(o_conv_irq_enable)
      |-> !o_conv_complete_flag) else $error("flag set with irq enabled");
   chk_irq_cause: assert property ($rose(o_conv_irq)
      |-> o_conv_irq_enable && $past(o_busy)) else $error("irq without conversion");
   chk_irq_write: assert property (i_scr_write && !o_busy
      |=> !o_conv_irq) else $error("irq kept after control write");
   chk_store_busy: assert property ($rose(o_conv_complete_flag)
      |-> $past(o_busy)) else $error("flag set outside conversion");
   chk_right_high: assert property (o_result_format == `FMT_RIGHT ##0 store_seen
      |-> o_result_high_byte[7:2] == 6'h00) else $error("right layout high bits set");
   chk_trunc_high: assert property (o_result_format == `FMT_TRUNC ##0 store_seen
      |-> o_result_high_byte == 8'h00) else $error("truncated high byte set");
   chk_pin_oe: assert property (pins_settled
      |-> o_pin_oe == (i_port_ddr & ~sel_mask(o_mux_select))) else $error("pin enable wrong");
   chk_port_read: assert property (pins_settled ##0 o_mux_select[4:3] == 2'h0
      |-> o_port_read[o_mux_select[2:0]] == 1'b0) else $error("selected pin read not 0");
endmodule
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench for the converter sequencer
// Assumes: inputs driven 1 ns after the rising edge
// Notes:   PRESCALE shortened to 4 system cycles per tick
`include "adc_seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
   import adc_seq_pkg::*;
   localparam int P = 4;
   logic i_clk_sys = 1'b0, i_rst_n = 1'b0, scr_wr = 1'b0, ie = 1'b0, co = 1'b0, cfg_wr = 1'b0;
   logic src = 1'b0, alt = 1'b0, rd_h = 1'b0, rd_l = 1'b0, cmp, flag, irq, busy, pd;
   channel_select_t chan = 5'h1F, mux, chan_rb;
   conv_divider_t div = 3'h0;
   result_format_t fmt = 2'h0;
   logic [7:0] pdata = 8'h00, pddr = 8'h00, pin = 8'h00, hi, lo, pout, poe, pread;
   logic [9:0] trial, lvl [8];
   int failures = 0, n_checks = 0, ac = 0;
   always #5 i_clk_sys = ~i_clk_sys;
   always begin
      @(posedge i_clk_sys);
      #1;
      ac = (ac + 1) % 5;
      alt = (ac == 0);
   end
   adc_sequencer #(.PRESCALE(P)) DUT (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_scr_write(scr_wr),
      .i_conv_irq_enable(ie), .i_continuous_conv_bit(co), .i_channel_select_field(chan),
      .i_clk_cfg_write(cfg_wr), .i_conv_clock_divider(div), .i_conv_clock_source_sel(src),
      .i_result_format(fmt), .i_alt_conv_tick(alt), .i_read_high(rd_h), .i_read_low(rd_l),
      .o_conv_irq_enable(), .o_continuous_conv_bit(), .o_channel_select_field(chan_rb),
      .o_conv_clock_divider(), .o_conv_clock_source_sel(), .o_result_format(),
      .o_conv_complete_flag(flag), .o_result_high_byte(hi), .o_result_low_byte(lo),
      .o_conv_irq(irq), .o_busy(busy), .i_comparator(cmp), .o_mux_select(mux),
      .o_power_down(pd), .o_sample(), .o_sar_trial(trial), .i_port_data(pdata),
      .i_port_ddr(pddr), .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe(poe), .o_port_read(pread)
   );
   adc_core_model u_core (
      .i_clk_sys(i_clk_sys), .i_sar_trial(trial), .i_mux_select(mux),
      .i_power_down(pd), .i_pin_level(lvl), .o_comparator(cmp)
   );
   // ============================================================
   // helpers
   task automatic give_verdict();
      if (failures == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic cmp_val(string n, logic [9:0] e, logic [9:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmp_rng(string n, int lo_b, int hi_b, int g);
      n_checks++;
      if (g < lo_b || g > hi_b) begin
         failures++;
         $display("mismatch %s expected %0d..%0d seen %0d", n, lo_b, hi_b, g);
      end
   endtask
   task automatic step(int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic set_cfg(conv_divider_t d, logic s, result_format_t f);
      div = d;
      src = s;
      fmt = f;
      cfg_wr = 1'b1;
      step(1);
      cfg_wr = 1'b0;
   endtask
   task automatic start(channel_select_t c, logic e, logic k);
      chan = c;
      ie = e;
      co = k;
      scr_wr = 1'b1;
      step(1);
      scr_wr = 1'b0;
   endtask
   task automatic rd(logic h, logic l);
      rd_h = h;
      rd_l = l;
      step(1);
      rd_h = 1'b0;
      rd_l = 1'b0;
      step(1);
   endtask
   task automatic wait_done(int lim, output int n);
      n = 0;
      while (flag !== 1'b1 && irq !== 1'b1) begin
         step(1);
         n++;
         if (n > lim) begin
            failures++;
            $display("mismatch completion expected done seen timeout");
            give_verdict();
         end
      end
   endtask
   function automatic logic [15:0] fmt_exp(result_format_t f, logic [9:0] r);
      case (f)
         `FMT_LEFT:   fmt_exp = {r, 6'h00};
         `FMT_RIGHT:  fmt_exp = {6'h00, r};
         `FMT_SIGNED: fmt_exp = {~r[9], r[8:0], 6'h00};
         default:     fmt_exp = {8'h00, r[9:2]};
      endcase
   endfunction
   // ============================================================
   // scenarios
   task automatic s_reset();
      cmp_val("reset channel", 5'h1F, chan_rb);
      cmp_val("reset power down", 1'b1, pd);
      cmp_val("reset flag", 1'b0, flag);
      cmp_val("reset busy", 1'b0, busy);
   endtask
   task automatic s_formats();
      channel_select_t tc [6] = '{5'h00, 5'h01, 5'h02, 5'h03, `CHAN_REF_HIGH, `CHAN_REF_LOW};
      logic [9:0] r;
      logic [15:0] e;
      int n, per;
      start(`CHAN_REF_HIGH, 1'b0, 1'b0);
      wait_done(40 * P, n);
      cmp_rng("settle cycles", 31 * P, 34 * P + 2, n);
      rd(1'b1, 1'b0);
      rd(1'b0, 1'b1);
      for (int k = 0; k < 6; k++) begin
         set_cfg((k == 4) ? 3'h2 : 3'h0, k == 5, result_format_t'(k));
         per = (k == 5) ? 5 : ((k == 4) ? 4 * P : P);
         r = (k == 4) ? 10'h3FF : ((k == 5) ? 10'h000 : lvl[k]);
         e = fmt_exp(result_format_t'(k), r);
         start(tc[k], 1'b0, 1'b0);
         wait_done(20 * per, n);
         cmp_rng("conversion cycles", 15 * per, 17 * per + 2, n);
         cmp_val("high byte", e[15:8], hi);
         cmp_val("low byte", e[7:0], lo);
         rd(1'b1, 1'b0);
         rd(1'b0, 1'b1);
      end
   endtask
   task automatic s_lock();
      logic [15:0] e;
      int n;
      set_cfg(3'h0, 1'b0, `FMT_LEFT);
      start(5'h00, 1'b0, 1'b0);
      wait_done(20 * P, n);
      rd(1'b1, 1'b0);
      lvl[0] = 10'h155;
      start(5'h00, 1'b0, 1'b0);
      step(20 * P);
      e = fmt_exp(`FMT_LEFT, 10'h2C5);
      cmp_val("flag while locked", 1'b0, flag);
      cmp_val("high byte locked", e[15:8], hi);
      rd(1'b0, 1'b1);
      start(5'h00, 1'b0, 1'b0);
      wait_done(20 * P, n);
      e = fmt_exp(`FMT_LEFT, 10'h155);
      cmp_val("high byte unlocked", e[15:8], hi);
      set_cfg(3'h0, 1'b0, `FMT_TRUNC);
      rd(1'b1, 1'b0);
      lvl[0] = 10'h0AA;
      start(5'h00, 1'b0, 1'b0);
      wait_done(20 * P, n);
      cmp_val("truncated no lock", 8'h2A, lo);
      rd(1'b0, 1'b1);
   endtask
   task automatic s_cont();
      int n;
      set_cfg(3'h0, 1'b0, `FMT_RIGHT);
      start(5'h01, 1'b0, 1'b1);
      wait_done(40 * P, n);
      lvl[1] = 10'h0F0;
      n = 0;
      while (lo !== 8'hF0 && n < 40 * P) begin
         step(1);
         n++;
      end
      cmp_val("continuous overwrite", 8'hF0, lo);
      cmp_val("flag held", 1'b1, flag);
      start(5'h01, 1'b0, 1'b0);
      step(20 * P);
      rd(1'b1, 1'b0);
      rd(1'b0, 1'b1);
      step(20 * P);
      cmp_val("single then idle", 1'b0, busy);
      cmp_val("no further result", 1'b0, flag);
   endtask
   task automatic s_irq();
      int n;
      start(5'h02, 1'b1, 1'b0);
      wait_done(20 * P, n);
      cmp_val("irq raised", 1'b1, irq);
      cmp_val("flag with irq", 1'b0, flag);
      rd(1'b0, 1'b1);
      step(1);
      cmp_val("irq after read", 1'b0, irq);
      start(5'h02, 1'b1, 1'b0);
      wait_done(20 * P, n);
      start(5'h02, 1'b1, 1'b0);
      step(1);
      cmp_val("irq after write", 1'b0, irq);
      start(5'h02, 1'b0, 1'b0);
   endtask
   task automatic s_ports();
      pdata = 8'hA5;
      pddr = 8'hFF;
      pin = 8'h3C;
      start(5'h02, 1'b0, 1'b0);
      step(6);
      cmp_val("pin enable", 8'hFB, poe);
      cmp_val("pin out", 8'hA5, pout);
      cmp_val("port read", 8'hA1, pread);
      pddr = 8'h00;
      step(6);
      cmp_val("port read input", 8'h38, pread);
      start(`CHAN_POWER_OFF, 1'b0, 1'b0);
      step(6);
      cmp_val("port read free", 8'h3C, pread);
      cmp_val("power down", 1'b1, pd);
   endtask
   // ============================================================
   // main sequence
   initial begin
      for (int k = 0; k < 8; k++) begin
         lvl[k] = 10'h2C5 + 10'(k * 37);
      end
      repeat (3) @(posedge i_clk_sys);
      #1;
      i_rst_n = 1'b1;
      step(1);
      s_reset();
      s_formats();
      s_lock();
      s_cont();
      s_irq();
      s_ports();
      give_verdict();
   end
endmodule
bind adc_sequencer adc_sequencer_asserts #(.PRESCALE(PRESCALE)) u_chk (
   .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_scr_write(i_scr_write),
   .i_channel_select_field(i_channel_select_field), .i_read_high(i_read_high),
   .i_read_low(i_read_low), .i_port_ddr(i_port_ddr), .o_conv_irq_enable(o_conv_irq_enable),
   .o_conv_complete_flag(o_conv_complete_flag), .o_result_high_byte(o_result_high_byte),
   .o_result_low_byte(o_result_low_byte), .o_result_format(o_result_format),
   .o_conv_irq(o_conv_irq), .o_busy(o_busy), .o_mux_select(o_mux_select),
   .o_power_down(o_power_down), .o_pin_oe(o_pin_oe), .o_port_read(o_port_read)
);
`default_nettype wire
